// *** core/osc_trim_mult.sv ***
// Oscillator trim registers, clock multiplier and core clock routing
`timescale 1ns/1ps
module osc_trim_mult #(
    parameter int LOCK_EDGES_P = osc_mult_pkg::LOCK_EDGES // Input edges to lock
) (
    input wire logic clk,                        // System clock, 125 MHz
    input wire logic rst_b,                      // Async reset, active low
    input wire logic ce,                         // Clock enable, freezes state when low
    input wire logic [7:0] sfr_addr,             // Register address
    input wire logic sfr_wr,                     // Write strobe
    input wire logic sfr_rd,                     // Read strobe
    input wire logic [7:0] sfr_wdata,            // Write data
    output logic [7:0] sfr_rdata,                // Read data, registered
    input wire logic [6:0] cal_coarse,           // Factory coarse calibration
    input wire logic [5:0] cal_fine,             // Factory fine calibration
    input wire logic int_osc_in,                 // Internal oscillator level
    input wire logic ext_osc_in,                 // External oscillator level
    input wire logic [1:0] core_clock_source_select, // Core clock source code
    output logic [6:0] trim_coarse,              // Coarse period trim to oscillator
    output logic [5:0] trim_fine,                // Fine period trim to oscillator
    output logic mult_tick,                      // Multiplier output pulse
    output logic mult_locked_flag,               // Multiplier locked
    output logic core_clock_tick                 // Routed core clock pulse, or the registered ext_osc_in level
);
    import osc_mult_pkg::*;

    mult_link_if link ();

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [6:0] coarse_reg;
    logic [6:0] coarse_next;
    logic [5:0] fine_reg;
    logic [5:0] fine_next;
    logic cal_pend_reg;
    logic cal_pend_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    mult_state_t state_reg;
    mult_state_t state_next;
    logic [7:0] edge_cnt_reg;
    logic [7:0] edge_cnt_next;
    logic prev_in_reg;
    logic prev_int_reg;
    logic [2:0] burst_reg;
    logic [2:0] burst_next;
    logic core_tick_reg;
    logic core_tick_next;
    logic [2:0] den;

    logic ctrl_wr;
    logic sel_in;
    logic in_rise;
    logic en;
    logic [1:0] sel;
    logic [2:0] scale;

    assign ctrl_wr = sfr_wr && sfr_addr == CTRL_ADDR;
    assign en = ctrl_reg[EN_BIT];
    assign sel = ctrl_reg[SEL_LSB +: SEL_W];
    assign scale = ctrl_reg[SCALE_LSB +: SCALE_W];
    assign sel_in = sel[0] ? ext_osc_in : int_osc_in;
    assign in_rise = sel_in && !prev_in_reg;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        coarse_next = coarse_reg;
        fine_next = fine_reg;
        cal_pend_next = 1'b0;
        rdata_next = rdata_reg;
        if (cal_pend_reg) begin
            coarse_next = cal_coarse;
            fine_next = cal_fine;
        end
        if (sfr_wr) begin
            case (sfr_addr)
                CTRL_ADDR: begin
                    ctrl_next = sfr_wdata;
                    ctrl_next[RDY_BIT] = 1'b0;
                end
                FINE_ADDR: fine_next = sfr_wdata[FINE_W-1:0];
                COARSE_ADDR: coarse_next = sfr_wdata[COARSE_W-1:0];
                default: ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                CTRL_ADDR: begin
                    rdata_next = ctrl_reg;
                    rdata_next[RDY_BIT] = (state_reg == ST_LOCKED);
                end
                FINE_ADDR: rdata_next = {2'h0, fine_reg};
                COARSE_ADDR: rdata_next = {1'b0, coarse_reg};
                default: rdata_next = UNMAPPED_READ;
            endcase
        end
    end

    // Calibration is taken on the first enabled edge after reset release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RESET;
            coarse_reg <= '0;
            fine_reg <= '0;
            cal_pend_reg <= 1'b1;
            rdata_reg <= 8'h00;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            coarse_reg <= coarse_next;
            fine_reg <= fine_next;
            cal_pend_reg <= cal_pend_next;
            rdata_reg <= rdata_next;
        end
    end

    // Larger code gives a shorter oscillator period
    assign trim_coarse = coarse_reg;
    assign trim_fine = fine_reg;
    assign sfr_rdata = rdata_reg;

    // ------------------------------------------------------------
    // Lock acquisition
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        edge_cnt_next = edge_cnt_reg;
        case (state_reg)
            ST_IDLE: edge_cnt_next = 8'h00;
            ST_ACQUIRE: begin
                if (in_rise) begin
                    if (edge_cnt_reg >= 8'(LOCK_EDGES_P - 1)) begin
                        state_next = ST_LOCKED;
                    end else begin
                        edge_cnt_next = edge_cnt_reg + 8'h01;
                    end
                end
            end
            ST_LOCKED: ;
            default: state_next = ST_IDLE;
        endcase
        if (ctrl_wr) begin
            if (sfr_wdata[EN_BIT] && sfr_wdata[INIT_BIT]) begin
                state_next = ST_ACQUIRE;
                edge_cnt_next = 8'h00;
            end else if (!sfr_wdata[EN_BIT] || sfr_wdata[SEL_LSB +: SEL_W] != sel) begin
                state_next = ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            edge_cnt_reg <= 8'h00;
        end else if (ce) begin
            state_reg <= state_next;
            edge_cnt_reg <= edge_cnt_next;
        end
    end

    assign mult_locked_flag = (state_reg == ST_LOCKED);

    // ------------------------------------------------------------
    // Pulse bursts per input rising edge, scale and routing
    // ------------------------------------------------------------
    always_comb begin
        burst_next = burst_reg;
        if (!en) begin
            burst_next = 3'h0;
        end else if (in_rise) begin
            burst_next = sel[1] ? BURST_X4 : BURST_X2;
        end else if (burst_reg != 3'h0) begin
            burst_next = burst_reg - 3'h1;
        end
    end

    always_comb begin
        den = DEN_NONE;
        if (sel[1]) begin
            case (scale)
                SCALE_2_3: den = DEN_3;
                SCALE_2_4: den = DEN_4;
                SCALE_2_5: den = DEN_5;
                SCALE_2_6: den = DEN_6;
                SCALE_2_7: den = DEN_7;
                default: den = DEN_NONE;
            endcase
        end
    end

    // Internal edges keep their own history, since prev_in_reg may follow the external line
    always_comb begin
        case (core_clock_source_select)
            SRC_INT: core_tick_next = int_osc_in && !prev_int_reg;
            SRC_EXT: core_tick_next = ext_osc_in;
            SRC_MULT: core_tick_next = link.out_tick;
            default: core_tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_in_reg <= 1'b0;
            prev_int_reg <= 1'b0;
            burst_reg <= 3'h0;
            core_tick_reg <= 1'b0;
        end else if (ce) begin
            prev_in_reg <= sel_in;
            prev_int_reg <= int_osc_in;
            burst_reg <= burst_next;
            core_tick_reg <= core_tick_next;
        end
    end

    assign link.ce = ce;
    assign link.base_tick = en && burst_reg != 3'h0;
    assign link.scale_den = den;
    assign mult_tick = link.out_tick;
    assign core_clock_tick = core_tick_reg;

    pulse_scaler u_scaler (
        .clk(clk),
        .rst_b(rst_b),
        .link(link)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seq_ctrl_write;
        ce && ctrl_wr;
    endsequence

    sequence seq_init_write;
        ce && ctrl_wr && sfr_wdata[EN_BIT] && sfr_wdata[INIT_BIT];
    endsequence

    coarse_bit7_a: assert property (ce && sfr_rd && sfr_addr == COARSE_ADDR |=> !sfr_rdata[7])
        else $error("coarse trim bit 7 read as one");
    coarse_write_a: assert property (ce && sfr_wr && sfr_addr == COARSE_ADDR && !cal_pend_reg
        |=> trim_coarse == $past(sfr_wdata[6:0])) else $error("coarse trim write lost");
    fine_top_a: assert property (ce && sfr_rd && sfr_addr == FINE_ADDR |=> sfr_rdata[7:6] == 2'h0)
        else $error("fine trim upper bits read nonzero");
    enable_write_a: assert property (seq_ctrl_write |=> en == $past(sfr_wdata[EN_BIT]))
        else $error("enable bit did not follow write");
    init_start_a: assert property (seq_init_write |=> state_reg == ST_ACQUIRE ##0 !mult_locked_flag)
        else $error("initialize did not start acquisition");
    ready_read_a: assert property (ce && sfr_rd && sfr_addr == CTRL_ADDR
        |=> sfr_rdata[RDY_BIT] == $past(mult_locked_flag)) else $error("ready flag read mismatch");
    x4_burst_a: assert property (ce && en && in_rise && sel[1] |=> burst_reg == BURST_X4)
        else $error("times-four burst length wrong");
    x2_burst_a: assert property (ce && en && in_rise && !sel[1] |=> burst_reg == BURST_X2)
        else $error("times-two burst length wrong");
    x2_noscale_a: assert property (!sel[1] |-> den == DEN_NONE)
        else $error("scale applied to times-two base");
    mult_route_a: assert property (ce && core_clock_source_select == SRC_MULT
        |=> core_clock_tick == $past(mult_tick)) else $error("multiplier not routed to core clock");

    // ------------------------------------------------------------
    // Calibration and trim checks
    // ------------------------------------------------------------
    sequence seq_cal_load;
        ce && cal_pend_reg && !sfr_wr;
    endsequence

    cal_coarse_a: assert property (seq_cal_load |=> trim_coarse == $past(cal_coarse))
        else $error("coarse trim missed its calibration value");
    cal_fine_a: assert property (seq_cal_load |=> trim_fine == $past(cal_fine))
        else $error("fine trim missed its calibration value");
    fine_write_a: assert property (ce && sfr_wr && sfr_addr == FINE_ADDR
        |=> trim_fine == $past(sfr_wdata[5:0])) else $error("fine trim write lost");

    // ------------------------------------------------------------
    // Lock and pulse checks
    // ------------------------------------------------------------
    sequence seq_last_edge;
        ce && state_reg == ST_ACQUIRE && in_rise && !ctrl_wr && edge_cnt_reg >= 8'(LOCK_EDGES_P - 1);
    endsequence

    sequence seq_burst_step;
        ce && en && !in_rise && burst_reg != 3'h0;
    endsequence

    lock_done_a: assert property (seq_last_edge |=> mult_locked_flag)
        else $error("lock not reached after the last acquisition edge");
    lock_hold_a: assert property (ce && mult_locked_flag && !ctrl_wr |=> mult_locked_flag)
        else $error("lock dropped without a control write");
    disable_unlock_a: assert property (seq_ctrl_write ##0 !sfr_wdata[EN_BIT] |=> !mult_locked_flag)
        else $error("lock survived disable");
    mult_quiet_a: assert property (ce && !en |=> !mult_tick)
        else $error("multiplier pulse while disabled");
    burst_step_a: assert property (seq_burst_step |=> burst_reg == $past(burst_reg) - 3'h1)
        else $error("burst did not count down");
    x2_pass_a: assert property (ce && en && !sel[1] && link.base_tick |=> mult_tick)
        else $error("times-two base pulse was scaled");
    scale_seven_a: assert property (sel[1] && scale == SCALE_2_7 |-> den == DEN_7)
        else $error("scale code seven not mapped to 2/7");
    scale_one_a: assert property (sel[1] && scale == SCALE_1 |-> den == DEN_NONE)
        else $error("scale code zero applied scaling");

endmodule : osc_trim_mult

// *** core/osc_mult_pkg.sv ***
// Constants for the oscillator trim and clock multiplier block
//
// What this block does
// - Coarse trim register: bits 6:0 read/write period, bit 7 reads zero.
// - Coarse trim zero is the slowest oscillator, all ones the fastest.
// - Coarse trim loads a factory value for 24 MHz after reset.
// - Fine trim register: bits 5:0 read/write, bits 7:6 read zero.
// - Fine trim adjusts the period finely and resets to a factory value.
// - Multiplier output is two or four times input; the times-four output is scaled by 1 down to 2/7.
// - Input select 00 int x2, 01 ext x2, 10 int x4, 11 ext x4.
// - With a times-two base selected, the scale field is ignored.
// - Scale code 111 gives 2/7; fractional duty cycle may differ from half.
// - Control bit 7 enables the multiplier and resets to zero.
// - Writing initialize together with the enable bit starts lock acquisition.
// - Ready flag in bit 5 reads one only when locked.
// - Slow inputs give four fast pulses per input rising edge with select bit 1 set, two with it clear.
// - Core clock source code 10 routes the multiplier output to the core.
package osc_mult_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h97;
    localparam logic [7:0] FINE_ADDR = 8'h9e;
    localparam logic [7:0] COARSE_ADDR = 8'ha2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int EN_BIT = 7;
    localparam int INIT_BIT = 6;
    localparam int RDY_BIT = 5;
    localparam int SCALE_LSB = 2;
    localparam int SCALE_W = 3;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam int COARSE_W = 7;
    localparam int FINE_W = 6;

    // ------------------------------------------------------------
    // Scale codes and denominators (zero means no scaling)
    // ------------------------------------------------------------
    localparam logic [2:0] SCALE_1 = 3'h0;
    localparam logic [2:0] SCALE_2_3 = 3'h1;
    localparam logic [2:0] SCALE_2_4 = 3'h2;
    localparam logic [2:0] SCALE_2_5 = 3'h3;
    localparam logic [2:0] SCALE_2_6 = 3'h4;
    localparam logic [2:0] SCALE_2_7 = 3'h7;
    localparam logic [2:0] DEN_NONE = 3'h0;
    localparam logic [2:0] DEN_3 = 3'h3;
    localparam logic [2:0] DEN_4 = 3'h4;
    localparam logic [2:0] DEN_5 = 3'h5;
    localparam logic [2:0] DEN_6 = 3'h6;
    localparam logic [2:0] DEN_7 = 3'h7;
    localparam logic [2:0] SCALE_PASS = 3'h2;

    // ------------------------------------------------------------
    // Burst lengths, lock, core clock source codes
    // ------------------------------------------------------------
    localparam logic [2:0] BURST_X2 = 3'h2;
    localparam logic [2:0] BURST_X4 = 3'h4;
    localparam int LOCK_EDGES = 8;
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_MULT = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_LOCKED} mult_state_t;

endpackage : osc_mult_pkg

// *** core/mult_link_if.sv ***
// Tick stream and scale setting between multiplier core and scaler
`timescale 1ns/1ps
interface mult_link_if;
    logic ce;
    logic base_tick;
    logic [2:0] scale_den;
    logic out_tick;

    modport core (output ce, output base_tick, output scale_den, input out_tick);
    modport scaler (input ce, input base_tick, input scale_den, output out_tick);
endinterface : mult_link_if

// *** core/pulse_scaler.sv ***
// Fractional pulse scaler: passes two of every N base pulses
`timescale 1ns/1ps
module pulse_scaler (
    input wire logic clk,          // System clock
    input wire logic rst_b,        // Async reset, active low
    mult_link_if.scaler link       // Base ticks in, scaled ticks out
);
    import osc_mult_pkg::*;

    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic out_reg;
    logic out_next;

    // ------------------------------------------------------------
    // Phase counter: pulses at phase 0 and 1 pass, the rest are dropped
    // ------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        out_next = 1'b0;
        if (link.base_tick) begin
            if (link.scale_den == DEN_NONE) begin
                out_next = 1'b1;
                phase_next = 3'h0;
            end else begin
                out_next = (phase_reg < SCALE_PASS);
                if (phase_reg >= link.scale_den - 3'h1) begin
                    phase_next = 3'h0;
                end else begin
                    phase_next = phase_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 3'h0;
            out_reg <= 1'b0;
        end else if (link.ce) begin
            phase_reg <= phase_next;
            out_reg <= out_next;
        end
    end

    assign link.out_tick = out_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sev_drop_a: assert property (link.ce && link.base_tick && link.scale_den == DEN_7
        && phase_reg >= SCALE_PASS |=> !out_reg) else $error("2/7 scaler passed a dropped pulse");
    pass_all_a: assert property (link.ce && link.base_tick && link.scale_den == DEN_NONE
        |=> out_reg) else $error("unscaled base pulse was dropped");

endmodule : pulse_scaler

// *** sim/osc_trim_mult_tb.sv ***
// Self-checking bench for the trim registers and clock multiplier
`timescale 1ns/1ps
module osc_trim_mult_tb;
    import osc_mult_pkg::*;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [6:0] cal_coarse = 7'h35;
    logic [5:0] cal_fine = 6'h1a;
    logic int_osc_in = 1'b0;
    logic ext_osc_in = 1'b0;
    logic [1:0] core_clock_source_select = 2'h2;
    logic [6:0] trim_coarse;
    logic [5:0] trim_fine;
    logic mult_tick;
    logic mult_locked_flag;
    logic core_clock_tick;
    int fails = 0;
    int n_tests = 0;
    int mt = 0;
    int ct = 0;
    logic counting = 1'b0;
    logic [7:0] rv;
    logic [7:0] cfg [12] = '{8'h02, 8'h06, 8'h0a, 8'h0e, 8'h12, 8'h1e, 8'h16, 8'h1a, 8'h03, 8'h1f, 8'h1c, 8'h0d};
    int ne [12] = '{2, 3, 4, 5, 6, 7, 2, 2, 2, 7, 4, 4};

    always #4 clk = ~clk;

    osc_trim_mult #(.LOCK_EDGES_P(2)) i_osc_trim_mult (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .cal_coarse(cal_coarse),
        .cal_fine(cal_fine),
        .int_osc_in(int_osc_in),
        .ext_osc_in(ext_osc_in),
        .core_clock_source_select(core_clock_source_select),
        .trim_coarse(trim_coarse),
        .trim_fine(trim_fine),
        .mult_tick(mult_tick),
        .mult_locked_flag(mult_locked_flag),
        .core_clock_tick(core_clock_tick)
    );

    // Output pulses counted inside a window
    always @(posedge clk) begin
        if (counting) begin
            if (mult_tick === 1'b1) mt = mt + 1;
            if (core_clock_tick === 1'b1) ct = ct + 1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        tick(1);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        tick(1);
        d = sfr_rdata;
    endtask : rd

    // Rising edges on the chosen line, slow enough to keep the scaled output within the core limit
    task automatic osc_edges(input int n, input logic ext);
        repeat (n) begin
            if (ext) ext_osc_in = 1'b1;
            else int_osc_in = 1'b1;
            tick(8);
            ext_osc_in = 1'b0;
            int_osc_in = 1'b0;
            tick(8);
        end
    endtask : osc_edges

    task automatic count_edges(input int n, input logic ext);
        mt = 0;
        ct = 0;
        counting = 1'b1;
        osc_edges(n, ext);
        counting = 1'b0;
    endtask : count_edges

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        tick(20);
        rst_b = 1'b1;
        tick(3);
        check("trim_coarse reset", {1'b0, trim_coarse}, {1'b0, cal_coarse});
        check("trim_fine reset", {2'b00, trim_fine}, {2'b00, cal_fine});
        rd(COARSE_ADDR, rv);
        check("coarse reset read", rv, {1'b0, cal_coarse});
        rd(FINE_ADDR, rv);
        check("fine reset read", rv, {2'b00, cal_fine});
        rd(CTRL_ADDR, rv);
        check("ctrl reset read", rv, 8'h00);
        wr(COARSE_ADDR, 8'hff);
        rd(COARSE_ADDR, rv);
        check("coarse fastest", rv, 8'h7f);
        check("trim_coarse fastest", {1'b0, trim_coarse}, 8'h7f);
        wr(COARSE_ADDR, 8'h80);
        rd(COARSE_ADDR, rv);
        check("coarse slowest", rv, 8'h00);
        check("trim_coarse slowest", {1'b0, trim_coarse}, 8'h00);
        wr(FINE_ADDR, 8'hff);
        rd(FINE_ADDR, rv);
        check("fine all ones", rv, 8'h3f);
        check("trim_fine all ones", {2'b00, trim_fine}, 8'h3f);
        rd(8'h55, rv);
        check("unmapped read", rv, UNMAPPED_READ);
        ce = 1'b0;
        wr(FINE_ADDR, 8'h11);
        ce = 1'b1;
        rd(FINE_ADDR, rv);
        check("fine frozen by ce", rv, 8'h3f);
        wr(CTRL_ADDR, 8'h20);
        rd(CTRL_ADDR, rv);
        check("ready bit not writable", rv, 8'h00);
        wr(CTRL_ADDR, 8'h42);
        osc_edges(4, 1'b0);
        check("init without enable", {7'h00, mult_locked_flag}, 8'h00);

        // Every select code and scale code, each expecting eight output pulses
        for (int i = 0; i < 12; i++) begin
            wr(CTRL_ADDR, 8'h00);
            wr(CTRL_ADDR, cfg[i] & 8'h03);
            wr(CTRL_ADDR, cfg[i]);
            wr(CTRL_ADDR, cfg[i] | 8'h80);
            tick(640);
            check("locked before init", {7'h00, mult_locked_flag}, 8'h00);
            wr(CTRL_ADDR, cfg[i] | 8'hc0);
            osc_edges(7, cfg[i][0]);
            k = 0;
            while (mult_locked_flag !== 1'b1 && k < 50) begin
                tick(1);
                k++;
            end
            check("lock wait", {7'h00, mult_locked_flag}, 8'h01);
            rd(CTRL_ADDR, rv);
            check("ready after lock", {7'h00, rv[RDY_BIT]}, 8'h01);
            count_edges(ne[i], cfg[i][0]);
            check("mult pulses", 8'(mt), 8'h08);
            check("core pulses from mult", 8'(ct), 8'h08);
        end

        wr(CTRL_ADDR, 8'h00);
        tick(2);
        check("locked after disable", {7'h00, mult_locked_flag}, 8'h00);
        count_edges(2, 1'b0);
        check("no pulses when disabled", 8'(mt), 8'h00);
        core_clock_source_select = SRC_INT;
        count_edges(4, 1'b0);
        check("core pulses from int", 8'(ct), 8'h04);
        wr(CTRL_ADDR, 8'h01);
        count_edges(4, 1'b0);
        check("int pulses with ext selected", 8'(ct), 8'h04);
        core_clock_source_select = SRC_EXT;
        count_edges(4, 1'b1);
        check("core level from ext", 8'(ct), 8'h20);
        core_clock_source_select = 2'h3;
        count_edges(4, 1'b0);
        check("core pulses from none", 8'(ct), 8'h00);
        summarize();
    end
endmodule : osc_trim_mult_tb
